// *** core/sqd_pkg.sv ***
// Purpose: shared constants and types of the squib deployment controller
// Assumes: 20 MHz core clock, 16-bit serial frames
// Notes: frame = write flag, 3-bit address, 11-bit data, odd parity bit
package sqd_pkg;
   localparam int CLK_NS = 50;               // core clock period
   localparam int TICK_NS = 4000;            // on-time unit, 4 us
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int ON_TIME_MAX_US = 8200;     // longest firing time
   localparam int TAIL_NS = 100000;          // high-side to low-side off gap
   localparam int TAIL_TICKS = TAIL_NS / TICK_NS;
   localparam int FRAME_BITS = 16;
   localparam int DATA_W = 11;
   localparam int NCH = 4;
   // register addresses
   localparam logic [2:0] ADDR_CFG = 3'h0;
   localparam logic [2:0] ADDR_ARM = 3'h1;
   localparam logic [2:0] ADDR_ONT0 = 3'h2;  // on-time of channel 0, then 1..3
   localparam logic [2:0] ADDR_FIRE = 3'h6;
   localparam logic [2:0] ADDR_STAT = 3'h7;
   // config fields and arm keys
   localparam int CFG_HI_LIMIT_BIT = 0;      // 1: 1.75 A level, 0: 1.2 A level
   localparam int CFG_DEPLOY_BIT = 1;        // 1: deployment limits, 0: diagnostic
   localparam logic [10:0] ARM_KEY_A = 11'h5a5;
   localparam logic [10:0] ARM_KEY_B = 11'h35a;
   localparam logic [10:0] CFG_RESET = 11'h000;
   localparam logic [10:0] ONT_RESET = 11'h000;
   // frame field positions
   localparam int FR_WR_BIT = 15;
   localparam int FR_ADDR_LSB = 12;
   localparam int FR_DATA_LSB = 1;
   localparam int FIRE_LS_LSB = 4;

   typedef enum logic [1:0] {
      SQD_IDLE = 2'b00,
      SQD_FIRE = 2'b01,
      SQD_TAIL = 2'b11
   } sqd_chan_e;

   typedef struct packed {
      logic deploy_ok;                       // bit 10, live
      logic armed;                           // bit 9
      logic parity_err;                      // bit 8, sticky
      logic [3:0] timeout_done;              // bits 7:4, sticky
      logic [3:0] over_temp;                 // bits 3:0, sticky
   } sqd_status_s;
endpackage

// *** core/sqd_deploy_ctrl.sv ***
// Purpose: digital deployment control of a four-channel squib driver
// Assumes: host is serial master, mode 0 (sample on rising, shift on falling)
// Notes: all pins pass a three-stage synchroniser; the filter changes only when stages 2 and 3 agree
// Functional notes
// - after reset both switch sides use the diagnostic current limit
// - one config bit picks 1.2 A or 1.75 A high-side limit for all channels
// - each channel has its own programmable on-time, up to 8.2 ms
// - firing needs arm sequence, arm enable high and watchdog inhibit low
// - switches turn on only by serial command
// - on timeout high side off, low side off about 100 us later
// - active low reset pin holds the logic in reset
// - serial slave checks odd parity of every frame
// - high and low side of each channel are commanded separately
// - over-temperature during firing ends that channel's deployment
// - fault and diagnostic status is latched and readable over the link
// - low-side deployment limit has no register setting
`timescale 1ns/10ps
module sqd_deploy_ctrl
   import sqd_pkg::*;
(
   input wire logic core_clk,                // 20 MHz clock
   input wire logic reset,                   // synchronous, active high
   input wire logic dev_reset_n,             // device reset pin, active low
   input wire logic spi_sclk,                // serial clock pin
   input wire logic spi_cs_n,                // serial select pin, active low
   input wire logic spi_mosi,                // serial data in
   input wire logic arm_enable_input,        // hardware enable, high allows
   input wire logic watchdog_inhibit_input,  // hardware inhibit, high blocks
   input wire logic [3:0] over_temp,         // per-channel thermal flags
   output logic spi_miso,                    // serial data out
   output logic spi_miso_oe,                 // miso drive enable
   output logic [3:0] hs_on,                 // high-side switch gates
   output logic [3:0] ls_on,                 // low-side switch gates
   output logic hs_deploy_level,             // high side uses deployment limit
   output logic hs_limit_high,               // high side limit 1.75 A
   output logic ls_deploy_level              // low side uses its fixed deploy limit
);
   localparam int NPIN = 10;
   // idle pin levels: sclk low, select high, inhibit high, reset pin low, rest low
   localparam logic [NPIN-1:0] FILT_IDLE = 10'h012;
   localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
   localparam logic [10:0] TAIL_CNT = 11'(TAIL_TICKS - 1);

   // pin synchroniser: stage 1 feeds only stage 2; filter on 2 and 3
   logic [NPIN-1:0] pin_raw, s1_reg, s2_reg, s3_reg, filt_reg, filt_next, rise, fall;
   assign pin_raw = {dev_reset_n, over_temp, watchdog_inhibit_input,
                     arm_enable_input, spi_mosi, spi_cs_n, spi_sclk};
   assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
   assign rise = filt_next & ~filt_reg;
   assign fall = ~filt_next & filt_reg;
   always_ff @(posedge core_clk) begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // filters start at idle levels so no false edge follows reset;
      // the reset pin starts low so the logic waits for a clean release
      filt_reg <= reset ? FILT_IDLE : filt_next;
   end

   wire sclk_rise = rise[0];
   wire sclk_fall = fall[0];
   wire cs_n_f = filt_reg[1];
   wire cs_fall = fall[1];
   wire cs_rise = rise[1];
   wire mosi_f = filt_reg[2];
   wire arm_en_f = filt_reg[3];
   wire wdi_f = filt_reg[4];
   wire [3:0] ot_f = filt_reg[8:5];
   wire rst = reset | ~filt_reg[9];

   // odd parity helper
   function automatic logic odd_par(input logic [14:0] d);
      odd_par = ~(^d);
   endfunction

   // serial shifters
   logic [15:0] rx_reg, tx_reg;
   logic [4:0] bit_cnt_reg;
   logic [14:0] reply_reg, reply_next;
   wire frame_end = cs_rise;
   wire frame_ok = frame_end && (bit_cnt_reg == 5'(FRAME_BITS)) && (^rx_reg);
   wire frame_bad = frame_end && !frame_ok;
   wire fr_wr = rx_reg[FR_WR_BIT];
   wire [2:0] fr_addr = rx_reg[FR_ADDR_LSB +: 3];
   wire [10:0] fr_data = rx_reg[FR_DATA_LSB +: DATA_W];
   wire do_wr = frame_ok & fr_wr;
   wire do_rd = frame_ok & ~fr_wr;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_reg <= 16'h0000;
         tx_reg <= 16'h0000;
         bit_cnt_reg <= 5'h00;
      end else if (cs_fall) begin
         bit_cnt_reg <= 5'h00;
         tx_reg <= {reply_reg, odd_par(reply_reg)};
      end else if (!cs_n_f && sclk_rise) begin
         rx_reg <= {rx_reg[14:0], mosi_f};
         bit_cnt_reg <= (bit_cnt_reg == 5'h1f) ? bit_cnt_reg : bit_cnt_reg + 5'h01;
      end else if (!cs_n_f && sclk_fall) begin
         tx_reg <= {tx_reg[14:0], 1'b0};
      end
   end

   // configuration and on-time registers
   logic [10:0] cfg_reg;
   logic [10:0] ont_reg [NCH];
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_reg <= CFG_RESET;
         for (int i = 0; i < NCH; i++) ont_reg[i] <= ONT_RESET;
      end else if (do_wr) begin
         if (fr_addr == ADDR_CFG) cfg_reg <= fr_data;
         for (int i = 0; i < NCH; i++) begin
            if (fr_addr == ADDR_ONT0 + 3'(i)) ont_reg[i] <= fr_data;
         end
      end
   end

   // arm sequence: key A then key B; any other arm write disarms
   logic key_a_reg, armed_reg;
   wire arm_wr = do_wr && (fr_addr == ADDR_ARM);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         key_a_reg <= 1'b0;
         armed_reg <= 1'b0;
      end else if (arm_wr) begin
         key_a_reg <= (fr_data == ARM_KEY_A);
         armed_reg <= key_a_reg && (fr_data == ARM_KEY_B);
      end
   end
   // live gate: losing a hardware line blocks new turn-ons at once
   wire deploy_ok = armed_reg & arm_en_f & ~wdi_f;

   // 4 us tick divider for on-time and tail counting
   logic [6:0] div_reg;
   logic tick_reg;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         div_reg <= 7'h00;
         tick_reg <= 1'b0;
      end else begin
         div_reg <= (div_reg == TICK_LAST) ? 7'h00 : div_reg + 7'h01;
         tick_reg <= (div_reg == TICK_LAST);
      end
   end

   // per-channel firing sequencer
   sqd_chan_e st_reg [NCH], st_next [NCH];
   logic [10:0] cnt_reg [NCH], cnt_next [NCH];
   logic [3:0] hs_next, ls_next, tdone_evt, ot_evt;
   wire fire_wr = do_wr && (fr_addr == ADDR_FIRE);
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         st_next[i] = st_reg[i];
         cnt_next[i] = cnt_reg[i];
         hs_next[i] = hs_on[i];
         ls_next[i] = ls_on[i];
         tdone_evt[i] = 1'b0;
         ot_evt[i] = 1'b0;
         case (st_reg[i])
            SQD_IDLE, SQD_FIRE: begin
               if (fire_wr) begin
                  // sides are set apart; turn-off always honoured
                  hs_next[i] = fr_data[i] & (deploy_ok | hs_on[i]);
                  ls_next[i] = fr_data[FIRE_LS_LSB + i] & (deploy_ok | ls_on[i]);
               end
               if (st_reg[i] == SQD_IDLE) begin
                  if (hs_next[i] | ls_next[i]) begin
                     st_next[i] = SQD_FIRE;
                     cnt_next[i] = ont_reg[i];
                  end
               end else if (!(hs_next[i] | ls_next[i])) begin
                  st_next[i] = SQD_IDLE;
               end else if (tick_reg) begin
                  if (cnt_reg[i] == 11'h000) begin
                     hs_next[i] = 1'b0;
                     st_next[i] = SQD_TAIL;
                     cnt_next[i] = TAIL_CNT;
                  end else begin
                     cnt_next[i] = cnt_reg[i] - 11'h001;
                  end
               end
            end
            SQD_TAIL: begin
               // no retrigger while the low side is still finishing
               if (tick_reg) begin
                  if (cnt_reg[i] == 11'h000) begin
                     ls_next[i] = 1'b0;
                     st_next[i] = SQD_IDLE;
                     tdone_evt[i] = 1'b1;
                  end else begin
                     cnt_next[i] = cnt_reg[i] - 11'h001;
                  end
               end
            end
            default: begin
               hs_next[i] = 1'b0;
               ls_next[i] = 1'b0;
               st_next[i] = SQD_IDLE;
            end
         endcase
         // thermal shutdown overrides everything while a channel is active
         if (ot_f[i] && st_reg[i] != SQD_IDLE) begin
            hs_next[i] = 1'b0;
            ls_next[i] = 1'b0;
            st_next[i] = SQD_IDLE;
            ot_evt[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      for (int i = 0; i < NCH; i++) begin
         st_reg[i] <= rst ? SQD_IDLE : st_next[i];
         cnt_reg[i] <= rst ? 11'h000 : cnt_next[i];
      end
      hs_on <= rst ? 4'h0 : hs_next;
      ls_on <= rst ? 4'h0 : ls_next;
   end

   // latched status; a read clears sticky bits but a new event wins
   sqd_status_s stat_reg, stat_next;
   wire stat_clr = do_rd && (fr_addr == ADDR_STAT);
   always_comb begin
      stat_next = stat_reg;
      if (stat_clr) begin
         stat_next.parity_err = 1'b0;
         stat_next.timeout_done = 4'h0;
         stat_next.over_temp = 4'h0;
      end
      stat_next.parity_err = stat_next.parity_err | frame_bad;
      stat_next.timeout_done = stat_next.timeout_done | tdone_evt;
      stat_next.over_temp = stat_next.over_temp | ot_evt;
      stat_next.armed = armed_reg;
      stat_next.deploy_ok = deploy_ok;
   end

   // reply for the next frame: address echo and selected register
   wire [10:0] rd_val = (fr_addr == ADDR_CFG) ? cfg_reg :
                        (fr_addr == ADDR_FIRE) ? {3'h0, ls_on, hs_on} :
                        (fr_addr == ADDR_STAT) ? stat_reg :
                        (fr_addr >= ADDR_ONT0) ? ont_reg[2'(fr_addr - ADDR_ONT0)] :
                        {10'h000, armed_reg};
   always_comb begin
      reply_next = reply_reg;
      if (do_rd) reply_next = {1'b0, fr_addr, rd_val};
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         stat_reg <= '0;
         reply_reg <= 15'h0000;
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
         hs_deploy_level <= 1'b0;
         hs_limit_high <= 1'b0;
         ls_deploy_level <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         reply_reg <= reply_next;
         spi_miso <= tx_reg[15];
         spi_miso_oe <= ~cs_n_f;
         hs_deploy_level <= cfg_reg[CFG_DEPLOY_BIT];
         hs_limit_high <= cfg_reg[CFG_HI_LIMIT_BIT];
         // the low-side level follows only the diagnostic/deploy mode
         ls_deploy_level <= cfg_reg[CFG_DEPLOY_BIT];
      end
   end
endmodule

// *** tb/sqd_monitor.sv ***
// Purpose: port checker of the squib controller
// Assumes: sees the top ports only
// Notes: margins of a few clocks cover the pin synchroniser delay
`timescale 1ns/10ps
module sqd_monitor
   import sqd_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic reset, // core reset
   input wire logic dev_reset_n, // reset pin
   input wire logic spi_sclk, // serial clock
   input wire logic spi_cs_n, // select
   input wire logic spi_mosi, // data in
   input wire logic arm_enable_input, // enable
   input wire logic watchdog_inhibit_input, // inhibit
   input wire logic [3:0] over_temp, // hot flags
   input wire logic spi_miso, // data out
   input wire logic spi_miso_oe, // out enable
   input wire logic [3:0] hs_on, // high gates
   input wire logic [3:0] ls_on, // low gates
   input wire logic hs_deploy_level, // high level
   input wire logic hs_limit_high, // 1.75 A
   input wire logic ls_deploy_level // low level
);
   localparam int TAIL_CLKS = TAIL_NS / CLK_NS;
   localparam int TAIL_MIN = TAIL_CLKS - TICK_CYC;
   localparam int TAIL_MAX = TAIL_CLKS + TICK_CYC;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // helper: clocks since channel 0 high side dropped with its low side still on;
   // a counter keeps the long tail out of a delay range
   // limitation: assumes the high side dropped on timeout, not by command
   int tail_cnt;
   always_ff @(posedge core_clk) begin
      if (reset || hs_on[0] || !ls_on[0]) begin
         tail_cnt <= 0;
      end else if ($fell(hs_on[0]) || (tail_cnt != 0 && tail_cnt <= TAIL_MAX)) begin
         tail_cnt <= tail_cnt + 1;
      end
   end
   // a gate newly switched on
   sequence s_turn_on;
      ((hs_on & ~$past(hs_on)) | (ls_on & ~$past(ls_on))) != 4'h0;
   endsequence
   // low side outlasts the high side for a while
   sequence s_tail;
      ls_on[0] [*8];
   endsequence
   // low side of channel 0 dropping at the end of a counted tail
   sequence s_tail_end;
      $fell(ls_on[0]) && tail_cnt != 0;
   endsequence
   chk_pin_reset: assert property (!dev_reset_n [*8] |=> (hs_on | ls_on) == 4'h0)
      else $error("gate on while reset pin low");
   chk_reset_diag: assert property ($fell(reset) |-> !hs_deploy_level && !ls_deploy_level)
      else $error("deploy level right after reset");
   chk_arm_gate: assert property (s_turn_on |->
      $past(arm_enable_input, 8) && !$past(watchdog_inhibit_input, 8))
      else $error("turn-on without hardware enables");
   chk_cmd_only: assert property (s_turn_on |-> spi_cs_n && !$past(spi_cs_n, 20))
      else $error("turn-on outside a frame end");
   chk_tail_order: assert property ($fell(hs_on[0]) && ls_on[0] |=> s_tail)
      else $error("low side tail wrong");
   chk_tail_len: assert property (s_tail_end |-> tail_cnt inside {[TAIL_MIN:TAIL_MAX]})
      else $error("low side tail length wrong");
   chk_hot_off: assert property ((over_temp != 4'h0) [*8] |=>
      ((hs_on | ls_on) & over_temp) == 4'h0)
      else $error("hot channel still on");
   chk_oe_frame: assert property ($stable(spi_cs_n) [*8] |-> spi_miso_oe == !spi_cs_n)
      else $error("miso enable off frame");
   chk_ls_fixed: assert property ($changed(hs_limit_high) && $stable(hs_deploy_level) |->
      $stable(ls_deploy_level))
      else $error("low limit moved with high limit");
endmodule
bind sqd_deploy_ctrl sqd_monitor mon (.*);

// *** tb/sqd_host_model.sv ***
// Purpose: serial host model sending frames to the controller
// Assumes: mode 0, 16-bit frames, sclk high for 5 clocks and low for 6 clocks
// Notes: mosi shows the inverse of its last bit between frames
`timescale 1ns/10ps
module sqd_host_model (
   input wire logic core_clk, // clock
   input wire logic spi_miso, // reply line
   output logic spi_sclk, // serial clock
   output logic spi_cs_n, // select
   output logic spi_mosi // data out
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // one frame msb first; reply sampled at each sclk rise
   task automatic xfer(input logic [15:0] fr, output logic [15:0] rep);
      @(posedge core_clk) #5 spi_cs_n = 1'b0;
      repeat (6) @(posedge core_clk);
      for (int i = 15; i >= 0; i--) begin
         @(posedge core_clk) #5 spi_mosi = fr[i];
         repeat (5) @(posedge core_clk);
         #5 spi_sclk = 1'b1;
         rep[i] = spi_miso;
         repeat (5) @(posedge core_clk);
         #5 spi_sclk = 1'b0;
      end
      repeat (5) @(posedge core_clk);
      #5 spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // no stale bit on a released line
      repeat (10) @(posedge core_clk);
   endtask
endmodule

// *** tb/tb.sv ***
// Purpose: self-checking bench of the squib controller
// Assumes: host model owns the serial pins
// Notes: a tick is 80 clocks, so the tail costs 2000 clocks
`timescale 1ns/10ps
module tb;
   import sqd_pkg::*;
   logic core_clk, reset, dev_reset_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic arm_enable_input, watchdog_inhibit_input, hs_deploy_level, hs_limit_high;
   logic ls_deploy_level;
   logic [3:0] over_temp, hs_on, ls_on;
   logic [15:0] rep;
   int mismatches, compares, n;
   typedef struct packed {logic [10:0] cfg; logic [2:0] lim;} sqd_row_s;
   // config word beside {high level, 1.75 A, low level}
   // the last row moves only the 1.75 A select, so the low level must hold
   sqd_row_s rows [4] = '{'{11'h002, 3'h5}, '{11'h000, 3'h0}, '{11'h003, 3'h7}, '{11'h002, 3'h5}};
   sqd_deploy_ctrl dut (.*);
   sqd_host_model host (.*);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // odd parity over the whole frame
   function automatic logic [15:0] fr(logic wr, logic [2:0] a, logic [10:0] d);
      return {wr, a, d, ~^{wr, a, d}};
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic gates(input logic [7:0] exp);
      cmp({8'h0, hs_on, ls_on}, {8'h0, exp});
   endtask
   // current limit levels as {high level, 1.75 A, low level}
   task automatic levels(input logic [2:0] exp);
      cmp({13'h0, hs_deploy_level, hs_limit_high, ls_deploy_level}, {13'h0, exp});
   endtask
   // a read is answered in the following frame
   task automatic rd_reg(input logic [2:0] a, input logic [10:0] exp);
      host.xfer(fr(1'b0, a, 11'h000), rep);
      host.xfer(fr(1'b0, ADDR_ARM, 11'h000), rep);
      cmp({12'h0, ^rep, rep[14:12]}, {13'h1, a});
      cmp({5'h0, rep[11:1]}, {5'h0, exp});
   endtask
   task automatic rd_stat(input logic [10:0] exp);
      rd_reg(ADDR_STAT, exp);
   endtask
   task automatic close_out();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // watchdog: the run needs about 7700 clocks
   initial begin
      repeat (40000) @(posedge core_clk);
      mismatches++;
      close_out();
   end
   initial begin
      reset = 1'b1;
      dev_reset_n = 1'b0;
      arm_enable_input = 1'b1;
      watchdog_inhibit_input = 1'b0;
      over_temp = 4'h0;
      repeat (2) @(posedge core_clk);
      #5 reset = 1'b0;
      repeat (10) @(posedge core_clk);
      cmp({hs_on, ls_on, 5'h0, hs_deploy_level, hs_limit_high, ls_deploy_level}, 16'h0);
      #5 dev_reset_n = 1'b1;
      repeat (12) @(posedge core_clk);
      $display("reset test done");
      foreach (rows[i]) begin
         host.xfer(fr(1'b1, ADDR_CFG, rows[i].cfg), rep);
         levels(rows[i].lim);
      end
      host.xfer(fr(1'b1, ADDR_ARM, ARM_KEY_A), rep);
      host.xfer(fr(1'b1, ADDR_ARM, ARM_KEY_B), rep);
      rd_stat(11'h600);
      // either hardware line in its blocking level refuses a turn-on
      for (n = 0; n < 2; n++) begin
         #5 arm_enable_input = n[0];
         watchdog_inhibit_input = n[0];
         repeat (10) @(posedge core_clk);
         host.xfer(fr(1'b1, ADDR_FIRE, 11'h011), rep);
         gates(8'h00);
      end
      #5 arm_enable_input = 1'b1;
      watchdog_inhibit_input = 1'b0;
      repeat (10) @(posedge core_clk);
      $display("config and gate tests done");
      // ch0 both sides, ch1 high only, ch3 low only
      host.xfer(fr(1'b1, ADDR_ONT0, 11'h002), rep);
      // ch1 gets the same on-time so no early tick drops it before the gate check
      host.xfer(fr(1'b1, ADDR_ONT0 + 3'h1, 11'h002), rep);
      host.xfer(fr(1'b1, ADDR_FIRE, 11'h093), rep);
      gates(8'h39);
      n = 0;
      while (hs_on[0] === 1'b1 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      cmp({15'h0, n inside {[150:260]}}, 16'h1);
      cmp({15'h0, ls_on[0]}, 16'h1);
      n = 0;
      while (ls_on[0] === 1'b1 && n < 2400) begin
         @(posedge core_clk);
         n++;
      end
      cmp({15'h0, n inside {[1800:2100]}}, 16'h1);
      gates(8'h00);
      $display("timeout test done");
      // longest on-time, ended early by over-temperature
      host.xfer(fr(1'b1, ADDR_ONT0 + 3'h2, 11'h7ff), rep);
      host.xfer(fr(1'b1, ADDR_FIRE, 11'h044), rep);
      gates(8'h44);
      #5 over_temp = 4'h4;
      repeat (12) @(posedge core_clk);
      gates(8'h00);
      #5 over_temp = 4'h0;
      rd_stat(11'h6b4);
      host.xfer(fr(1'b1, ADDR_FIRE, 11'h088) ^ 16'h0001, rep);
      gates(8'h00);
      rd_stat(11'h700);
      rd_stat(11'h600);
      $display("fault test done");
      // pin reset in mid-fire drops the gates and restores every register
      host.xfer(fr(1'b1, ADDR_FIRE, 11'h011), rep);
      gates(8'h11);
      #5 dev_reset_n = 1'b0;
      repeat (8) @(posedge core_clk);
      gates(8'h00);
      levels(3'h0);
      #5 dev_reset_n = 1'b1;
      repeat (12) @(posedge core_clk);
      rd_reg(ADDR_ONT0, ONT_RESET);
      rd_stat(11'h000);
      $display("mid-run reset test done");
      close_out();
   end
endmodule
